// ===== design/codec_dp_pkg.sv
// Package: constants, register map and carrier types for the codec datapath.
// Assumes a 100 MHz system clock standing in for the internal master clock.
package codec_dp_pkg;
	// APB register byte offsets
	localparam logic [7:0] OFF_CTRL_A  = 8'h00;
	localparam logic [7:0] OFF_CTRL_C  = 8'h08;
	localparam logic [7:0] OFF_CTRL_D  = 8'h0c;
	localparam logic [7:0] OFF_CTRL_E  = 8'h10;
	localparam logic [7:0] OFF_TX_DATA = 8'h14;
	localparam logic [7:0] OFF_RX_DATA = 8'h18;
	localparam logic [7:0] OFF_STATUS  = 8'h1c;
	// Field positions
	localparam int BIT_DATA_MODE  = 0;
	localparam int BIT_MIXED_MODE = 1;
	localparam int BIT_REF_OUT    = 6;
	localparam int BIT_REF_DOUBLE = 7;
	localparam int BIT_MUTE       = 7;
	localparam int BIT_BYPASS     = 5;
	localparam int IGAIN_LSB      = 0;
	localparam int OGAIN_LSB      = 4;
	// Rates: MOD_DIV relative to the internal master clock, DEC_RATE relative to the modulator strobe
	localparam int MOD_DIV  = 8;
	localparam int DEC_RATE = 32;
	localparam int ORDER    = 3;
	localparam int ACC_W    = 16;
	// Widths and codes
	localparam logic [7:0]  CTRL_RST  = 8'h00;
	localparam logic [15:0] POS_FULL  = 16'h7fff;
	localparam logic [15:0] NEG_FULL  = 16'h8000;
	localparam logic [3:0]  CNT3_MAX  = 4'h7;
	localparam logic [4:0]  CNT32_MAX = 5'h1f;

	typedef struct packed {
		logic       ref_double_sel;
		logic       ref_out_enable;
		logic       mute;
		logic [2:0] output_gain;
		logic [2:0] input_gain;
		logic       interp_bypass;
	} analog_ctrl_t;
endpackage : codec_dp_pkg

// ===== design/sinc3_integ.sv
// One integrator stage with a wrap-around accumulator.
// Assumes the caller gates it with its own rate strobe.
`default_nettype none
module sinc3_integ
	import codec_dp_pkg::*;
#(
	parameter int W = ACC_W
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         sys_rst_i,
	// Data
	input  wire logic         en_i,
	input  wire logic [W-1:0] din_i,
	output logic      [W-1:0] dout_o
);
	if (W < 2) begin : g_width_check
		$error("sinc3_integ: width too small");
	end
	// Modular sum: overflow cancels out in the combs
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			dout_o <= '0;
		end else if (en_i) begin
			dout_o <= dout_o + din_i;
		end
	end
endmodule // sinc3_integ
`default_nettype wire

// ===== design/codec_sinc3_datapath.sv
// Codec datapath: sinc3 decimator, formatter, sinc3 interpolator, modulator, controls.
// Assumes clk_i is the internal master clock and APB master is synchronous.
//
// Behaviour
// [RULE_01] One modulator bit per strobe at master clock over eight feeds the decimator
// [RULE_02] Third-order sinc decimator, comb delay 32, output rate /256, 15 bits
// [RULE_03] Plain data mode: result shifted left one, LSB zero
// [RULE_04] Positive full scale or beyond gives 0x7fff
// [RULE_05] Mixed mode keeps 15 bits; top bit flags control versus data
// [RULE_06] Host samples are two's complement, 0x7fff top, 0x8000 bottom
// [RULE_07] Sinc3 interpolator raises host samples from /256 to /8
// [RULE_08] No new host sample: previous held sample is reused
// [RULE_09] Bypass bit E5 routes host samples around the interpolator
// [RULE_10] Digital modulator makes one bit per /8 strobe from interpolated data
// [RULE_11] Input gain field D[2:0] selects input gain
// [RULE_12] Output gain field D[6:4] selects output gain
// [RULE_13] Mute bit D7 silences the analog output pair
// [RULE_14] Reference select C7 doubles the reference
// [RULE_15] C6 enables the buffered reference pin
// [RULE_16] Input amplifier sampled by the same /8 strobe
// [RULE_17] All rates derived from the internal master clock
// [RULE_18] A1=1,A0=1 mixed mode; A0=1,A1=0 plain data mode
// [RULE_19] Wrap-around integrators, results scaled to output widths
// [RULE_20] Reset clears filter state, held samples and control bits
`default_nettype none
module codec_sinc3_datapath
	import codec_dp_pkg::*;
#(
	parameter int DIV = MOD_DIV,
	parameter int R   = DEC_RATE
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Modulator link
	input  wire logic        adc_bit_i,
	output logic             mod_strobe_o,
	output logic             dac_bit_o,
	// Analog controls
	output logic [2:0]       input_gain_o,
	output logic [2:0]       output_gain_o,
	output logic             analog_out_mute_o,
	output logic             ref_double_sel_o,
	output logic             ref_out_enable_o,
	// Sample events
	output logic             adc_valid_o
);
	if (DIV != MOD_DIV || R != DEC_RATE) begin : g_rate_check
		$error("codec_sinc3_datapath: rates fixed by filter widths");
	end

	// ----------------------------------------------------------------
	// Registers and strobes
	// ----------------------------------------------------------------
	logic [7:0]  control_reg_a_reg, control_reg_c_reg, control_reg_d_reg, control_reg_e_reg;
	logic [15:0] tx_hold_reg;
	logic [15:0] rx_word_reg;
	logic        tx_new_reg;
	logic [2:0]  div_reg;
	logic [4:0]  dec_cnt_reg;
	logic        strobe;
	logic        frame;
	logic        apb_wr, apb_rd;

	assign strobe = (div_reg == CNT3_MAX[2:0]);                         // [RULE_17]
	assign frame  = strobe && (dec_cnt_reg == CNT32_MAX);
	assign apb_wr = psel_i && penable_i && pwrite_i;
	assign apb_rd = psel_i && !penable_i && !pwrite_i;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			div_reg     <= '0;
			dec_cnt_reg <= '0;
		end else begin
			div_reg <= div_reg + 3'h1;                                // [RULE_01]
			if (strobe) dec_cnt_reg <= dec_cnt_reg + 5'h01;             // [RULE_02]
		end
	end

	// ----------------------------------------------------------------
	// APB control registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			control_reg_a_reg <= CTRL_RST;                               // [RULE_20]
			control_reg_c_reg <= CTRL_RST;
			control_reg_d_reg <= CTRL_RST;
			control_reg_e_reg <= CTRL_RST;
		end else if (apb_wr) begin
			if (paddr_i == OFF_CTRL_A) begin
				control_reg_a_reg <= pwdata_i[7:0];
			end else if (paddr_i == OFF_CTRL_C) begin
				control_reg_c_reg <= pwdata_i[7:0];
			end else if (paddr_i == OFF_CTRL_D) begin
				control_reg_d_reg <= pwdata_i[7:0];
			end else if (paddr_i == OFF_CTRL_E) begin
				control_reg_e_reg <= pwdata_i[7:0];
			end
		end
	end

	// Held host sample; a frame with no write reuses it
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			tx_hold_reg <= '0;
			tx_new_reg  <= 1'b0;
		end else begin
			if (apb_wr && paddr_i == OFF_TX_DATA) begin
				tx_hold_reg <= pwdata_i[15:0];                           // [RULE_06]
			end
			// Set wins over the frame clear
			if (apb_wr && paddr_i == OFF_TX_DATA) begin
				tx_new_reg <= 1'b1;
			end else if (frame) begin
				tx_new_reg <= 1'b0;                                      // [RULE_08]
			end
		end
	end

	// Zero-wait slave; read data registered in the setup cycle
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			prdata_o  <= '0;
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o  <= psel_i && !penable_i;
			pslverr_o <= 1'b0;
			if (apb_rd) begin
				if (paddr_i == OFF_CTRL_A) begin
					prdata_o <= {24'h000000, control_reg_a_reg};
				end else if (paddr_i == OFF_CTRL_C) begin
					prdata_o <= {24'h000000, control_reg_c_reg};
				end else if (paddr_i == OFF_CTRL_D) begin
					prdata_o <= {24'h000000, control_reg_d_reg};
				end else if (paddr_i == OFF_CTRL_E) begin
					prdata_o <= {24'h000000, control_reg_e_reg};
				end else if (paddr_i == OFF_TX_DATA) begin
					prdata_o <= {16'h0000, tx_hold_reg};
				end else if (paddr_i == OFF_RX_DATA) begin
					prdata_o <= {16'h0000, rx_word_reg};
				end else if (paddr_i == OFF_STATUS) begin
					prdata_o <= {31'h00000000, tx_new_reg};
				end else begin
					prdata_o  <= '0;
					pslverr_o <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Decimator: three integrators, three combs of delay one output
	// ----------------------------------------------------------------
	// Gain 32^3 = 2^15, so 16-bit wrap-around holds the full range
	logic [ACC_W-1:0] i1, i2, i3;
	logic [ACC_W-1:0] c1_reg, c2_reg, c3_reg;
	logic [ACC_W-1:0] d1, d2, d3;
	logic [ACC_W-1:0] bit_val;

	assign bit_val = adc_bit_i ? 16'h0001 : 16'h0000;                    // [RULE_16]

	sinc3_integ #(.W(ACC_W)) u_di1 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .en_i(strobe), .din_i(bit_val), .dout_o(i1));
	sinc3_integ #(.W(ACC_W)) u_di2 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .en_i(strobe), .din_i(i1), .dout_o(i2));
	sinc3_integ #(.W(ACC_W)) u_di3 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .en_i(strobe), .din_i(i2), .dout_o(i3)); // [RULE_19]

	assign d1 = i3 - c1_reg;
	assign d2 = d1 - c2_reg;
	assign d3 = d2 - c3_reg;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			c1_reg <= '0;
			c2_reg <= '0;
			c3_reg <= '0;
		end else if (frame) begin
			c1_reg <= i3;                                                 // [RULE_02]
			c2_reg <= d1;
			c3_reg <= d2;
		end
	end

	// ----------------------------------------------------------------
	// Output formatting
	// ----------------------------------------------------------------
	// Count 0..32768 doubled and offset to two's complement; 32768 wraps, so saturate
	logic [ACC_W-1:0] bip;
	logic             at_full;
	logic [15:0]      rx_next;
	assign bip     = {d3[ACC_W-2:0], 1'b0} ^ NEG_FULL;
	assign at_full = (d3 == NEG_FULL);                                    // [RULE_04]

	always_comb begin
		rx_next = {bip[15:1], 1'b0};                                      // [RULE_03]
		if (at_full) rx_next = POS_FULL;                                  // [RULE_04]
		if (control_reg_a_reg[BIT_MIXED_MODE] && control_reg_a_reg[BIT_DATA_MODE]) begin
			// Top bit zero marks a sample frame
			rx_next = at_full ? {1'b0, POS_FULL[15:1]} : {1'b0, bip[15:1]}; // [RULE_05] [RULE_18]
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rx_word_reg <= '0;
			adc_valid_o <= 1'b0;
		end else begin
			adc_valid_o <= frame;
			if (frame) rx_word_reg <= rx_next;
		end
	end

	// ----------------------------------------------------------------
	// Interpolator: combs at frame rate, integrators at /8
	// ----------------------------------------------------------------
	localparam int IW = ACC_W + 15;
	logic [IW-1:0] x_in, ic1_reg, ic2_reg, ic3_reg, e1, e2, e3, e3_reg;
	logic [IW-1:0] j1, j2, j3;
	logic [IW-1:0] up_in;

	assign x_in = {{(IW-16){tx_hold_reg[15]}}, tx_hold_reg};             // [RULE_08]
	assign e1 = x_in - ic1_reg;
	assign e2 = e1 - ic2_reg;
	assign e3 = e2 - ic3_reg;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ic1_reg <= '0;
			ic2_reg <= '0;
			ic3_reg <= '0;
			e3_reg  <= '0;
		end else begin
			if (frame) begin
				ic1_reg <= x_in;                                          // [RULE_07]
				ic2_reg <= e1;
				ic3_reg <= e2;
				e3_reg  <= e3;
			end else if (strobe) begin
				e3_reg <= '0;                                             // Zero-stuffing
			end
		end
	end

	assign up_in = strobe ? e3_reg : '0;
	sinc3_integ #(.W(IW)) u_ui1 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .en_i(strobe), .din_i(up_in), .dout_o(j1));
	sinc3_integ #(.W(IW)) u_ui2 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .en_i(strobe), .din_i(j1), .dout_o(j2));
	sinc3_integ #(.W(IW)) u_ui3 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .en_i(strobe), .din_i(j2), .dout_o(j3)); // [RULE_19]

	// ----------------------------------------------------------------
	// Digital modulator (first-order error feedback)
	// ----------------------------------------------------------------
	logic [15:0] mod_in;
	logic [16:0] sd_acc_reg;
	logic [16:0] sd_sum;
	// Zero-stuffing leaves a gain of R^(N-1), removed by slicing
	localparam int UP_GAIN_LOG2 = $clog2(R) * (ORDER - 1);
	assign mod_in = control_reg_e_reg[BIT_BYPASS] ? tx_hold_reg : j3[UP_GAIN_LOG2 +: ACC_W]; // [RULE_09] [RULE_07]
	assign sd_sum = sd_acc_reg + {1'b0, mod_in ^ NEG_FULL};

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sd_acc_reg   <= '0;
			dac_bit_o    <= 1'b0;
			mod_strobe_o <= 1'b0;
		end else begin
			mod_strobe_o <= strobe;                                       // [RULE_01] [RULE_16]
			if (strobe) begin
				dac_bit_o  <= sd_sum[16];                                 // [RULE_10]
				sd_acc_reg <= {1'b0, sd_sum[15:0]};
			end
		end
	end

	// ----------------------------------------------------------------
	// Analog control outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			input_gain_o      <= '0;
			output_gain_o     <= '0;
			analog_out_mute_o <= 1'b0;
			ref_double_sel_o  <= 1'b0;
			ref_out_enable_o  <= 1'b0;
		end else begin
			input_gain_o      <= control_reg_d_reg[IGAIN_LSB +: 3];         // [RULE_11]
			output_gain_o     <= control_reg_d_reg[OGAIN_LSB +: 3];         // [RULE_12]
			analog_out_mute_o <= control_reg_d_reg[BIT_MUTE];               // [RULE_13]
			ref_double_sel_o  <= control_reg_c_reg[BIT_REF_DOUBLE];         // [RULE_14]
			ref_out_enable_o  <= control_reg_c_reg[BIT_REF_OUT];            // [RULE_15]
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_strobe_period: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		mod_strobe_o |=> !mod_strobe_o [*7] ##1 mod_strobe_o) else $error("strobe not every 8"); // [RULE_01]
	a_frame_rate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		adc_valid_o |=> !adc_valid_o [*8]) else $error("frame too soon"); // [RULE_02]
	a_plain_lsb: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		adc_valid_o && control_reg_a_reg == 8'h01 && rx_word_reg != POS_FULL |-> !rx_word_reg[0])
		else $error("plain mode lsb set"); // [RULE_03]
	a_full_code: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		frame && at_full && !control_reg_a_reg[BIT_MIXED_MODE] |=> rx_word_reg == POS_FULL)
		else $error("full scale code wrong"); // [RULE_04]
	a_mixed_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		frame && control_reg_a_reg[1:0] == 2'h3 |=> !rx_word_reg[15]) else $error("mixed flag set"); // [RULE_05]
	a_bypass_path: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		strobe && control_reg_e_reg[BIT_BYPASS] && tx_hold_reg == NEG_FULL |=> !dac_bit_o)
		else $error("bypass not taken"); // [RULE_09]
	a_hold_reuse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!(apb_wr && paddr_i == OFF_TX_DATA) |=> tx_hold_reg == $past(tx_hold_reg)) else $error("hold lost"); // [RULE_08]
	a_mute_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		apb_wr && paddr_i == OFF_CTRL_D |-> ##2 analog_out_mute_o == $past(pwdata_i[7], 2))
		else $error("mute wrong"); // [RULE_13]
	a_reset_clear: assert property (@(posedge clk_i)
		sys_rst_i |=> control_reg_d_reg == CTRL_RST && tx_hold_reg == 16'h0000) else $error("reset left state"); // [RULE_20]
endmodule // codec_sinc3_datapath
`default_nettype wire

// ===== test/mod_partner.sv
// Model of the analog modulator pair across the one-bit link.
// Assumes bits are sampled one clock before mod_strobe_i pulses.
`default_nettype none
module mod_partner (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// Link
	input  wire logic        mod_strobe_i,
	input  wire logic        dac_bit_i,
	input  wire logic [1:0]  pat_i,
	output logic             adc_bit_o,
	output logic      [15:0] ones_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Input modulator bits
	// ----------------------------------------
	// New bit right after the pulse, so it stays put for the next sample
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			adc_bit_o <= 1'b0;
		else if (mod_strobe_i)
			adc_bit_o <= (pat_i == 2'h2) ? ~adc_bit_o : pat_i[0];
	end
	// ----------------------------------------
	// Output stream density
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			ones_o <= 16'h0000;
		else if (mod_strobe_i && dac_bit_i)
			ones_o <= ones_o + 16'h0001;
	end
endmodule // mod_partner
`default_nettype wire

// ===== test/tb_top.sv
// Testbench for the codec datapath: APB tasks and modulator partner.
// Assumes zero-wait APB answers and a 100 MHz clock.
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top
	import codec_dp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        adc_bit, mod_strobe, dac_bit, mute, ref_dbl, ref_out, adc_valid;
	logic [2:0]  in_gain, out_gain;
	logic [1:0]  pat;
	logic [15:0] ones, ones0;
	int          err_count, checks_done, cyc, n, s;
	logic [1:0]  apat [5] = '{2'h1, 2'h0, 2'h2, 2'h0, 2'h2};
	logic [7:0]  amode [5] = '{8'h01, 8'h01, 8'h01, 8'h03, 8'h03};
	logic [31:0] aexp [5] = '{32'h7fff, 32'h8000, 32'h0000, 32'h4000, 32'h0000};
	codec_sinc3_datapath codec_sinc3_datapath_inst (.clk_i(clk), .sys_rst_i(sys_rst), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .adc_bit_i(adc_bit), .mod_strobe_o(mod_strobe),
		.dac_bit_o(dac_bit), .input_gain_o(in_gain), .output_gain_o(out_gain), .analog_out_mute_o(mute),
		.ref_double_sel_o(ref_dbl), .ref_out_enable_o(ref_out), .adc_valid_o(adc_valid));
	mod_partner mod_partner_inst (.clk_i(clk), .sys_rst_i(sys_rst), .mod_strobe_i(mod_strobe),
		.dac_bit_i(dac_bit), .pat_i(pat), .adc_bit_o(adc_bit), .ones_o(ones));
	// ----------------------------------------
	// Clock, timeout, verdict
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic close_out();
		$display("Checks %0d, errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Whole run is near 15000 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			close_out();
		end
	end
	// ----------------------------------------
	// Bus and event tasks
	// ----------------------------------------
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50)
			err_count++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic er;
		apb(1'b1, a, d, rd, er);
	endtask
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic ee);
		logic [31:0] rd;
		logic er;
		apb(1'b0, a, 32'h0, rd, er);
		`CHK(nm, e, rd)
		`CHK("slverr", ee, er)
	endtask
	// Counts cycles and strobes until the next word event
	task automatic wait_valid();
		n = 0;
		s = 0;
		do begin
			@(posedge clk);
			n++;
			if (mod_strobe === 1'b1)
				s++;
		end while (adc_valid !== 1'b1 && n < 400);
		if (n >= 400)
			err_count++;
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{psel, penable, pwrite, paddr, pwdata, pat} = '0;
		sys_rst = 1'b1;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		#1;
		`CHK("out ctrl", 9'h000, {in_gain, out_gain, mute, ref_dbl, ref_out})
		rd_chk("ctrl a", OFF_CTRL_A, 32'h0, 1'b0);
		rd_chk("ctrl d", OFF_CTRL_D, 32'h0, 1'b0);
		rd_chk("ctrl e", OFF_CTRL_E, 32'h0, 1'b0);
		rd_chk("tx data", OFF_TX_DATA, 32'h0, 1'b0);
		rd_chk("unmapped", 8'h04, 32'h0, 1'b1);
		for (int i = 0; i < 8; i++) begin
			wr(OFF_CTRL_D, {24'h0, i[0], i[2:0], 1'b0, 3'(7 - i)});
			wr(OFF_CTRL_C, {24'h0, i[1:0], 6'h00});
			@(posedge clk);
			#1;
			`CHK("in gain", 3'(7 - i), in_gain)
			`CHK("out gain", i[2:0], out_gain)
			`CHK("mute", i[0], mute)
			`CHK("ref sel", i[1:0], {ref_dbl, ref_out})
			rd_chk("ctrl d rb", OFF_CTRL_D, {24'h0, i[0], i[2:0], 1'b0, 3'(7 - i)}, 1'b0);
		end
		wait_valid();
		wait_valid();
		`CHK("word gap", 256, n)
		`CHK("strobes", 32, s)
		for (int i = 0; i < 5; i++) begin
			wr(OFF_CTRL_A, {24'h0, amode[i]});
			pat <= apat[i];
			repeat (5) wait_valid();
			rd_chk("rx word", OFF_RX_DATA, aexp[i], 1'b0);
		end
		// Host writes once; later intervals reuse the held sample
		for (int i = 0; i < 4; i++) begin
			wr(OFF_CTRL_E, {26'h0, ~i[1], 5'h00});
			wr(OFF_TX_DATA, i[0] ? 32'h8000 : 32'h7fff);
			rd_chk("ctrl e rb", OFF_CTRL_E, {26'h0, ~i[1], 5'h00}, 1'b0);
			rd_chk("status new", OFF_STATUS, 32'h1, 1'b0);
			repeat (4) wait_valid();
			ones0 = ones;
			repeat (4) wait_valid();
			if (i[0])
				`CHK("dac low", 1'b1, (ones - ones0) <= 16'd16)
			else
				`CHK("dac high", 1'b1, (ones - ones0) >= 16'd112)
			rd_chk("status old", OFF_STATUS, 32'h0, 1'b0);
		end
		close_out();
	end
endmodule // tb_top
`undef CHK
`default_nettype wire
